// ===== bcd_block_command_decoder.sv
// Block command decoder with APB register access, block cache and medium store
`timescale 1ns/10ps
module bcd_block_command_decoder
  import bcd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic media_fault,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bcd_state_t state;
  logic [31:0] cmd0_reg, cmd1_reg;
  logic [15:0] cmd2_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] cur_lba_reg;
  logic [15:0] cnt_reg;
  logic [3:0] flush_idx_reg;
  logic [1:0] flush_kind_reg;
  logic through_reg, verify_reg, xfer_err_reg;
  logic busy_reg, status_valid_reg;
  logic [7:0] status_code_reg, asc_reg;
  logic [3:0] key_reg, power_reg;
  logic ready_reg, wcd_reg, deferred_reg, deferred_next;
  logic [31:0] cache_mem [BCD_DEPTH];
  logic [31:0] medium_mem [BCD_DEPTH];
  logic [BCD_DEPTH-1:0] cache_valid_reg, dirty_reg;
  logic [7:0] op, b1, b4;
  logic [31:0] lba, read_word, rdata_mux;
  logic [15:0] xlen;
  logic [3:0] pc;
  logic [BCD_IDX_W-1:0] cur_idx;
  logic acc, wr_fire, rd_fire, go, din_fire, dout_fire, flush_wr, flush_last, mismatch;
  logic chk;
  logic [3:0] chk_key;
  logic [7:0] chk_asc;

  // Opcode classes
  function automatic logic known_op(input logic [7:0] o);
    known_op = (o == BCD_OP_TUR) || (o == BCD_OP_INQUIRY) || (o == BCD_OP_START_STOP) ||
               (o == BCD_OP_READ) || (o == BCD_OP_WRITE) || (o == BCD_OP_VERIFY) ||
               (o == BCD_OP_SYNC) || (o == BCD_OP_WBUF) || (o == BCD_OP_MSELECT) ||
               (o == BCD_OP_MSENSE);
  endfunction

  function automatic logic needs_media(input logic [7:0] o);
    needs_media = (o == BCD_OP_READ) || (o == BCD_OP_WRITE) || (o == BCD_OP_VERIFY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command block field extraction, most significant byte first
  assign op = cmd0_reg[31:24];
  assign b1 = cmd0_reg[23:16];
  assign lba = {cmd0_reg[15:0], cmd1_reg[31:16]};
  assign xlen = {cmd1_reg[7:0], cmd2_reg[15:8]};
  assign b4 = cmd1_reg[31:24];
  assign pc = b4[7:4];
  assign cur_idx = cur_lba_reg[BCD_IDX_W-1:0];

  // Bus handshake terms
  assign acc = psel & penable & ~pready_reg;
  assign wr_fire = psel & penable & pready_reg & pwrite;
  assign rd_fire = psel & penable & pready_reg & ~pwrite;
  assign go = wr_fire && (paddr == BCD_OFF_CTRL) && pwdata[BCD_CTRL_GO_BIT] && !busy_reg;
  assign din_fire = wr_fire && (paddr == BCD_OFF_DATA) && (state == BCD_S_DIN);
  assign dout_fire = rd_fire && (paddr == BCD_OFF_DATA) && (state == BCD_S_DOUT);

  // Newest copy wins: cache when held there, else medium
  assign read_word = cache_valid_reg[cur_idx] ? cache_mem[cur_idx] : medium_mem[cur_idx];
  assign flush_wr = (state == BCD_S_FLUSH) && dirty_reg[flush_idx_reg];
  assign flush_last = (state == BCD_S_FLUSH) && (flush_idx_reg == BCD_LAST_IDX);
  assign mismatch = medium_mem[cur_idx] != cache_mem[cur_idx];

  ////////////////////////////////////////////////////////////////////////////
  // Command validation; ignored fields are never looked at
  always_comb begin
    chk = 1'b0;
    chk_key = BCD_KEY_NONE;
    chk_asc = BCD_ASC_NONE;
    if (deferred_reg) begin
      chk = 1'b1;
      chk_key = BCD_KEY_MEDIUM;
      chk_asc = BCD_ASC_WRITE_ERR;
    end else if (!known_op(op)) begin
      chk = 1'b1;
      chk_key = BCD_KEY_ILLEGAL;
      chk_asc = BCD_ASC_BAD_OP;
    end else if ((needs_media(op) || op == BCD_OP_SYNC) && b1[BCD_B1_RELATIVE_ADDRESSING]) begin
      chk = 1'b1;
      chk_key = BCD_KEY_ILLEGAL;
      chk_asc = BCD_ASC_BAD_FIELD;
    end else if (op == BCD_OP_START_STOP && (pc == 4'h4 || pc > BCD_PWR_SLEEP)) begin
      chk = 1'b1;
      chk_key = BCD_KEY_ILLEGAL;
      chk_asc = BCD_ASC_BAD_FIELD;
    end else if (needs_media(op) && power_reg != BCD_PWR_ACTIVE) begin
      chk = 1'b1;
      chk_key = BCD_KEY_ILLEGAL;
      chk_asc = BCD_ASC_POWER;
    end else if (needs_media(op) && !ready_reg) begin
      chk = 1'b1;
      chk_key = BCD_KEY_NOT_READY;
      chk_asc = BCD_ASC_NOT_READY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command block registers, locked while a command runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd0_reg <= 32'h0;
      cmd1_reg <= 32'h0;
      cmd2_reg <= 16'h0;
    end else if (pce && wr_fire && !busy_reg) begin
      if (paddr == BCD_OFF_CMD0) cmd0_reg <= pwdata;
      if (paddr == BCD_OFF_CMD1) cmd1_reg <= pwdata;
      if (paddr == BCD_OFF_CMD2) cmd2_reg <= pwdata[31:16];
    end
  end

  // Read data selection
  always_comb begin
    case (paddr)
      BCD_OFF_CMD0: rdata_mux = cmd0_reg;
      BCD_OFF_CMD1: rdata_mux = cmd1_reg;
      BCD_OFF_CMD2: rdata_mux = {cmd2_reg, 16'h0};
      BCD_OFF_STATUS: rdata_mux = {status_code_reg, asc_reg, key_reg, power_reg, 3'h0,
                                   deferred_reg, wcd_reg, ready_reg, status_valid_reg, busy_reg};
      BCD_OFF_DATA: rdata_mux = (state == BCD_S_DOUT) ? read_word : 32'h0;
      default: rdata_mux = 32'h0;
    endcase
  end

  // APB answer: one wait cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else if (pce) begin
      pready_reg <= acc;
      pslverr_reg <= acc && (paddr > BCD_OFF_DATA || paddr[1:0] != 2'h0);
      if (acc) prdata_reg <= rdata_mux;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= BCD_S_IDLE;
      cur_lba_reg <= 32'h0;
      cnt_reg <= 16'h0;
      flush_idx_reg <= 4'h0;
      flush_kind_reg <= BCD_FK_SYNC;
      through_reg <= 1'b0;
      verify_reg <= 1'b0;
    end else if (pce) begin
      case (state)
        BCD_S_IDLE: begin
          if (go) state <= BCD_S_DECODE;
        end
        BCD_S_DECODE: begin
          cur_lba_reg <= lba;
          cnt_reg <= xlen;
          flush_idx_reg <= 4'h0;
          through_reg <= b1[BCD_B1_FUA] | wcd_reg | (op == BCD_OP_VERIFY);
          verify_reg <= (op == BCD_OP_VERIFY);
          state <= BCD_S_FINISH;
          if (!chk) begin
            case (op)
              BCD_OP_READ: begin
                if (xlen != 16'h0) state <= BCD_S_DOUT;
              end
              BCD_OP_WRITE, BCD_OP_VERIFY: begin
                if (xlen != 16'h0) state <= BCD_S_DIN;
              end
              BCD_OP_SYNC: begin
                state <= BCD_S_FLUSH;
                flush_kind_reg <= BCD_FK_SYNC;
              end
              BCD_OP_START_STOP: begin
                // Power field overrides start; load_eject is never used
                if (pc == BCD_PWR_SLEEP) begin
                  state <= BCD_S_FLUSH;
                  flush_kind_reg <= BCD_FK_SLEEP;
                end else if (pc == BCD_PWR_NOCHG && !b4[BCD_B4_START]) begin
                  state <= BCD_S_FLUSH;
                  flush_kind_reg <= BCD_FK_STOP;
                end
              end
              default: state <= BCD_S_FINISH;
            endcase
          end
        end
        BCD_S_DIN: begin
          if (din_fire) begin
            cur_lba_reg <= cur_lba_reg + 32'h1;
            cnt_reg <= cnt_reg - 16'h1;
            if (cnt_reg == 16'h1) begin
              if (verify_reg) begin
                state <= BCD_S_VERIFY;
                cur_lba_reg <= lba;
                cnt_reg <= xlen;
              end else begin
                state <= BCD_S_FINISH;
              end
            end
          end
        end
        BCD_S_DOUT: begin
          if (dout_fire) begin
            cur_lba_reg <= cur_lba_reg + 32'h1;
            cnt_reg <= cnt_reg - 16'h1;
            if (cnt_reg == 16'h1) state <= BCD_S_FINISH;
          end
        end
        BCD_S_FLUSH: begin
          flush_idx_reg <= flush_idx_reg + 4'h1;
          if (flush_last) state <= BCD_S_FINISH;
        end
        BCD_S_VERIFY: begin
          cur_lba_reg <= cur_lba_reg + 32'h1;
          cnt_reg <= cnt_reg - 16'h1;
          if (cnt_reg == 16'h1) state <= BCD_S_FINISH;
        end
        BCD_S_FINISH: state <= BCD_S_IDLE;
        default: state <= BCD_S_IDLE;
      endcase
    end
  end

  // Transfer error: failed forced write or failed verify
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_err_reg <= 1'b0;
    end else if (pce) begin
      if (state == BCD_S_DECODE) xfer_err_reg <= 1'b0;
      else if (din_fire && through_reg && media_fault) xfer_err_reg <= 1'b1;
      else if (state == BCD_S_VERIFY && mismatch) xfer_err_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status reporting: early for immediate start/stop other than sleep, else at finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      status_valid_reg <= 1'b0;
      status_code_reg <= BCD_STAT_GOOD;
      key_reg <= BCD_KEY_NONE;
      asc_reg <= BCD_ASC_NONE;
    end else if (pce) begin
      if (go) begin
        busy_reg <= 1'b1;
        status_valid_reg <= 1'b0;
      end else if (state == BCD_S_DECODE) begin
        status_code_reg <= chk ? BCD_STAT_CHECK : BCD_STAT_GOOD;
        key_reg <= chk_key;
        asc_reg <= chk_asc;
        if (!chk && op == BCD_OP_START_STOP && b1[BCD_B1_IMMED] && pc != BCD_PWR_SLEEP)
          status_valid_reg <= 1'b1;
      end else if (state == BCD_S_FINISH) begin
        busy_reg <= 1'b0;
        status_valid_reg <= 1'b1;
        if (xfer_err_reg && !status_valid_reg) begin
          status_code_reg <= BCD_STAT_CHECK;
          key_reg <= BCD_KEY_MEDIUM;
          asc_reg <= verify_reg ? BCD_ASC_MISCOMPARE : BCD_ASC_WRITE_ERR;
        end
      end
    end
  end

  // Power state, readiness and write policy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_reg <= BCD_PWR_ACTIVE;
      ready_reg <= 1'b1;
      wcd_reg <= 1'b0;
    end else if (pce) begin
      if (state == BCD_S_DECODE && !chk && op == BCD_OP_SYNC) begin
        wcd_reg <= b1[BCD_B1_WCD];
      end
      if (state == BCD_S_DECODE && !chk && op == BCD_OP_START_STOP) begin
        if (pc == BCD_PWR_ACTIVE || pc == BCD_PWR_IDLE || pc == BCD_PWR_STANDBY)
          power_reg <= pc;
        else if (pc == BCD_PWR_NOCHG && b4[BCD_B4_START])
          ready_reg <= 1'b1;
      end
      if (flush_last && flush_kind_reg == BCD_FK_STOP) ready_reg <= 1'b0;
      if (flush_last && flush_kind_reg == BCD_FK_SLEEP) power_reg <= BCD_PWR_SLEEP;
    end
  end

  // Deferred error: a failed background flush; set beats clear
  always_comb begin
    deferred_next = (deferred_reg & (state != BCD_S_DECODE)) | (flush_wr & media_fault);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) deferred_reg <= 1'b0;
    else if (pce) deferred_reg <= deferred_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache and medium storage; a medium fault drops the medium write
  always_ff @(posedge pclk) begin
    if (pce) begin
      if (din_fire) cache_mem[cur_idx] <= pwdata;
      if (din_fire && through_reg && !media_fault) medium_mem[cur_idx] <= pwdata;
      if (flush_wr && !media_fault) medium_mem[flush_idx_reg] <= cache_mem[flush_idx_reg];
    end
  end

  // Per-block valid and dirty flags; flush leaves blocks cached
  genvar gi;
  generate
    for (gi = 0; gi < BCD_DEPTH; gi++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cache_valid_reg[gi] <= 1'b0;
          dirty_reg[gi] <= 1'b0;
        end else if (pce) begin
          if (din_fire && cur_idx == BCD_IDX_W'(gi)) begin
            cache_valid_reg[gi] <= 1'b1;
            dirty_reg[gi] <= !through_reg || media_fault;
          end else if (flush_wr && flush_idx_reg == BCD_IDX_W'(gi) && !media_fault) begin
            dirty_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !pce);

  AST_ZERO_LEN_GOOD: assert property (
    (state == BCD_S_DECODE && !chk && needs_media(op) && xlen == 16'h0)
      |=> (state == BCD_S_FINISH) ##1 (status_valid_reg && status_code_reg == BCD_STAT_GOOD))
    else $error("zero length did not finish good");
  AST_START_ADDR: assert property (
    (state == BCD_S_DECODE && !chk && op == BCD_OP_READ && xlen != 16'h0)
      |=> (state == BCD_S_DOUT && cur_lba_reg == $past(lba) && cnt_reg == $past(xlen)))
    else $error("read start address or length wrong");
  AST_WRITE_NEWEST: assert property (
    din_fire |=> (cache_valid_reg[$past(cur_idx)] && cache_mem[$past(cur_idx)] == $past(pwdata)))
    else $error("written block not newest in cache");
  AST_POWER_REJECT: assert property (
    (state == BCD_S_DECODE && !deferred_reg && op == BCD_OP_READ && !b1[BCD_B1_RELATIVE_ADDRESSING] &&
     power_reg != BCD_PWR_ACTIVE)
      |=> (status_code_reg == BCD_STAT_CHECK && key_reg == BCD_KEY_ILLEGAL && asc_reg == BCD_ASC_POWER))
    else $error("media command not rejected in low power");
  AST_SLEEP_LATE: assert property (
    (state == BCD_S_DECODE && !chk && op == BCD_OP_START_STOP && pc == BCD_PWR_SLEEP)
      |=> (!status_valid_reg && busy_reg) [*8])
    else $error("sleep reported status early");
  AST_IMMED_EARLY: assert property (
    (state == BCD_S_DECODE && !chk && op == BCD_OP_START_STOP && pc == BCD_PWR_NOCHG &&
     !b4[BCD_B4_START] && b1[BCD_B1_IMMED])
      |=> (status_valid_reg && busy_reg && state == BCD_S_FLUSH))
    else $error("immediate stop status not early");
  AST_STOP_AFTER_FLUSH: assert property (
    $fell(ready_reg) |-> ($past(state) == BCD_S_FLUSH && $past(flush_kind_reg) == BCD_FK_STOP &&
                          $past(flush_idx_reg) == BCD_LAST_IDX))
    else $error("stop without full flush");
  AST_FLUSH_CLEANS: assert property (
    (flush_wr && !media_fault)
      |=> (!dirty_reg[$past(flush_idx_reg)] && medium_mem[$past(flush_idx_reg)] == cache_mem[$past(flush_idx_reg)]))
    else $error("flush left block dirty");
  AST_FORCED_LATE: assert property (
    (state == BCD_S_DIN && through_reg) |-> (!status_valid_reg && busy_reg))
    else $error("forced write reported early");
  AST_DEFERRED_REPORT: assert property (
    (state == BCD_S_DECODE && deferred_reg && !(flush_wr && media_fault))
      |=> (!deferred_reg && status_code_reg == BCD_STAT_CHECK && key_reg == BCD_KEY_MEDIUM))
    else $error("deferred error not reported");

  COV_READ_DONE: cover property ((state == BCD_S_DOUT) ##1 (state == BCD_S_FINISH));
  COV_VERIFY_DONE: cover property ((state == BCD_S_VERIFY) ##1 (state == BCD_S_FINISH));
  COV_SLEEP: cover property ($changed(power_reg) && power_reg == BCD_PWR_SLEEP);
  COV_DEFERRED: cover property ((state == BCD_S_DECODE) && deferred_reg);

endmodule

// ===== bcd_host_model.sv
// Host initiator model: APB master that loads and runs block commands
`timescale 1ns/10ps
module bcd_host_model
  import bcd_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd; // Stale data is not left on the bus
    @(posedge pclk);
  endtask
  // Command block packed most significant byte first, then go
  task automatic load(input logic [7:0] op, input logic [7:0] b1, input logic [31:0] lba, input logic [15:0] len);
    logic [31:0] rd;
    logic e;
    apb(1'b1, BCD_OFF_CMD0, {op, b1 & 8'hef, lba[31:16]}, rd, e);
    apb(1'b1, BCD_OFF_CMD1, {lba[15:0], 8'h00, len[15:8]}, rd, e);
    apb(1'b1, BCD_OFF_CMD2, {len[7:0], 24'h0}, rd, e);
    apb(1'b1, BCD_OFF_CTRL, 32'h1, rd, e);
  endtask
  // Poll status until idle with status valid
  task automatic finish(output logic [31:0] st);
    logic e;
    do begin
      apb(1'b0, BCD_OFF_STATUS, 32'h0, st, e);
    end while (st[0] !== 1'b0 || st[1] !== 1'b1);
  endtask
endmodule

// ===== bcd_pkg.sv
// Constants for the block command decoder: register map, command fields, status codes
package bcd_pkg;
  // Register map, byte addresses
  localparam int BCD_AW = 8;
  localparam logic [7:0] BCD_OFF_CMD0 = 8'h00;
  localparam logic [7:0] BCD_OFF_CMD1 = 8'h04;
  localparam logic [7:0] BCD_OFF_CMD2 = 8'h08;
  localparam logic [7:0] BCD_OFF_CTRL = 8'h0c;
  localparam logic [7:0] BCD_OFF_STATUS = 8'h10;
  localparam logic [7:0] BCD_OFF_DATA = 8'h14;
  localparam int BCD_CTRL_GO_BIT = 0;
  // Storage shape
  localparam int BCD_DEPTH = 16;
  localparam int BCD_IDX_W = 4;
  localparam logic [3:0] BCD_LAST_IDX = 4'hf;
  // Opcodes
  localparam logic [7:0] BCD_OP_TUR = 8'h00;
  localparam logic [7:0] BCD_OP_INQUIRY = 8'h12;
  localparam logic [7:0] BCD_OP_START_STOP = 8'h1b;
  localparam logic [7:0] BCD_OP_READ = 8'h28;
  localparam logic [7:0] BCD_OP_WRITE = 8'h2a;
  localparam logic [7:0] BCD_OP_VERIFY = 8'h2e;
  localparam logic [7:0] BCD_OP_SYNC = 8'h35;
  localparam logic [7:0] BCD_OP_WBUF = 8'h3b;
  localparam logic [7:0] BCD_OP_MSELECT = 8'h55;
  localparam logic [7:0] BCD_OP_MSENSE = 8'h5a;
  // Field positions within byte 1 and byte 4
  localparam int BCD_B1_RELATIVE_ADDRESSING = 0;
  localparam int BCD_B1_IMMED = 0;
  localparam int BCD_B1_WCD = 2;
  localparam int BCD_B1_FUA = 3;
  localparam int BCD_B4_START = 0;
  localparam int BCD_B4_LOAD_EJECT = 1;
  // Power conditions
  localparam logic [3:0] BCD_PWR_NOCHG = 4'h0;
  localparam logic [3:0] BCD_PWR_ACTIVE = 4'h1;
  localparam logic [3:0] BCD_PWR_IDLE = 4'h2;
  localparam logic [3:0] BCD_PWR_STANDBY = 4'h3;
  localparam logic [3:0] BCD_PWR_SLEEP = 4'h5;
  // Status byte, sense keys, sense codes
  localparam logic [7:0] BCD_STAT_GOOD = 8'h00;
  localparam logic [7:0] BCD_STAT_CHECK = 8'h02;
  localparam logic [3:0] BCD_KEY_NONE = 4'h0;
  localparam logic [3:0] BCD_KEY_NOT_READY = 4'h2;
  localparam logic [3:0] BCD_KEY_MEDIUM = 4'h3;
  localparam logic [3:0] BCD_KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] BCD_ASC_NONE = 8'h00;
  localparam logic [7:0] BCD_ASC_NOT_READY = 8'h04;
  localparam logic [7:0] BCD_ASC_WRITE_ERR = 8'h0c;
  localparam logic [7:0] BCD_ASC_MISCOMPARE = 8'h1d;
  localparam logic [7:0] BCD_ASC_BAD_OP = 8'h20;
  localparam logic [7:0] BCD_ASC_BAD_FIELD = 8'h24;
  localparam logic [7:0] BCD_ASC_POWER = 8'h2c;
  // Flush follow-up actions
  localparam logic [1:0] BCD_FK_SYNC = 2'h0;
  localparam logic [1:0] BCD_FK_STOP = 2'h1;
  localparam logic [1:0] BCD_FK_SLEEP = 2'h2;
  // Controller states
  typedef enum logic [2:0] {
    BCD_S_IDLE = 3'b000,
    BCD_S_DECODE = 3'b001,
    BCD_S_DIN = 3'b010,
    BCD_S_DOUT = 3'b011,
    BCD_S_FLUSH = 3'b100,
    BCD_S_VERIFY = 3'b101,
    BCD_S_FINISH = 3'b110
  } bcd_state_t;
endpackage

// ===== block_command_decoder_tb_top.sv
// Testbench for the block command decoder
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module block_command_decoder_tb_top import bcd_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic media_fault = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st, rd, d0, d1;
  logic [3:0] lba;
  logic [7:0] nm [6] = '{BCD_OP_TUR, BCD_OP_INQUIRY, BCD_OP_MSELECT, BCD_OP_MSENSE, BCD_OP_WBUF, BCD_OP_SYNC};
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  bcd_block_command_decoder dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .media_fault(media_fault), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bcd_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock of 100 ns period
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [19:0] ex(input logic [7:0] s, input logic [3:0] k, input logic [7:0] a);
    return {s, a, k};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [31:0] a, input logic [15:0] len);
    host.load(op, b1, a, len);
    host.finish(st);
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      results();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'hb628b5b3));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    host.apb(1'b0, BCD_OFF_STATUS, 32'h0, st, err);
    `CHK(st, 32'h0000_0104);
    host.apb(1'b0, 8'h18, 32'h0, rd, err);
    `CHK(err, 1'b1);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++) begin
      lba = 4'($urandom);
      d0 = $urandom;
      d1 = $urandom;
      host.load(i[0] ? BCD_OP_VERIFY : BCD_OP_WRITE, 8'($urandom) & 8'h08, {28'h0, lba}, 16'd2);
      host.apb(1'b1, BCD_OFF_DATA, d0, rd, err);
      host.apb(1'b1, BCD_OFF_DATA, d1, rd, err);
      host.finish(st);
      `CHK(st[31:12], ex(BCD_STAT_GOOD, BCD_KEY_NONE, BCD_ASC_NONE));
      host.load(BCD_OP_READ, 8'h00, {28'h0, lba + 4'h1}, 16'd1);
      host.apb(1'b0, BCD_OFF_DATA, 32'h0, rd, err);
      host.finish(st);
      `CHK(rd, d1);
    end
    run(BCD_OP_READ, 8'h00, 32'h0, 16'd0);
    `CHK(st[31:12], ex(BCD_STAT_GOOD, BCD_KEY_NONE, BCD_ASC_NONE));
    foreach (nm[k]) begin
      run(nm[k], 8'h00, 32'h0, 16'd0);
      `CHK(st[31:12], ex(BCD_STAT_GOOD, BCD_KEY_NONE, BCD_ASC_NONE));
    end
    run(BCD_OP_READ, 8'h01, 32'h0, 16'd1);
    `CHK(st[31:12], ex(BCD_STAT_CHECK, BCD_KEY_ILLEGAL, BCD_ASC_BAD_FIELD));
    $display("test data and opcodes done");
    run(BCD_OP_START_STOP, 8'h00, 32'h2000, 16'd0);
    `CHK(st[11:8], BCD_PWR_IDLE);
    run(BCD_OP_READ, 8'h00, 32'h0, 16'd1);
    `CHK(st[31:12], ex(BCD_STAT_CHECK, BCD_KEY_ILLEGAL, BCD_ASC_POWER));
    run(BCD_OP_START_STOP, 8'h00, 32'h2000, 16'd0);
    `CHK(st[31:12], ex(BCD_STAT_GOOD, BCD_KEY_NONE, BCD_ASC_NONE));
    run(BCD_OP_START_STOP, 8'h00, 32'h4000, 16'd0);
    `CHK(st[31:12], ex(BCD_STAT_CHECK, BCD_KEY_ILLEGAL, BCD_ASC_BAD_FIELD));
    run(BCD_OP_START_STOP, 8'h00, 32'h1200, 16'd0);
    `CHK({st[11:8], st[2]}, {BCD_PWR_ACTIVE, 1'b1});
    $display("test power done");
    media_fault <= 1'b1;
    host.load(BCD_OP_WRITE, 8'h08, 32'h3, 16'd1);
    host.apb(1'b1, BCD_OFF_DATA, 32'h5a5a_0001, rd, err);
    host.finish(st);
    `CHK(st[31:12], ex(BCD_STAT_CHECK, BCD_KEY_MEDIUM, BCD_ASC_WRITE_ERR));
    host.load(BCD_OP_WRITE, 8'h00, 32'h3, 16'd1);
    host.apb(1'b1, BCD_OFF_DATA, 32'h5a5a_0002, rd, err);
    host.finish(st);
    `CHK(st[31:12], ex(BCD_STAT_GOOD, BCD_KEY_NONE, BCD_ASC_NONE));
    run(BCD_OP_SYNC, 8'h00, 32'h0, 16'd0);
    `CHK(st[4], 1'b1);
    media_fault <= 1'b0;
    run(BCD_OP_TUR, 8'h00, 32'h0, 16'd0);
    `CHK(st[31:12], ex(BCD_STAT_CHECK, BCD_KEY_MEDIUM, BCD_ASC_WRITE_ERR));
    run(BCD_OP_TUR, 8'h00, 32'h0, 16'd0);
    `CHK(st[31:12], ex(BCD_STAT_GOOD, BCD_KEY_NONE, BCD_ASC_NONE));
    run(BCD_OP_SYNC, 8'h04, 32'h0, 16'd0);
    `CHK(st[3], 1'b1);
    media_fault <= 1'b1;
    host.load(BCD_OP_WRITE, 8'h00, 32'h5, 16'd1);
    host.apb(1'b1, BCD_OFF_DATA, 32'h5a5a_0003, rd, err);
    host.finish(st);
    `CHK(st[31:12], ex(BCD_STAT_CHECK, BCD_KEY_MEDIUM, BCD_ASC_WRITE_ERR));
    media_fault <= 1'b0;
    run(BCD_OP_SYNC, 8'h00, 32'h0, 16'd0);
    `CHK({st[4], st[3]}, 2'b00);
    $display("test faults done");
    run(BCD_OP_START_STOP, 8'h00, 32'h0, 16'd0);
    `CHK({st[4], st[2]}, 2'b00);
    run(BCD_OP_READ, 8'h00, 32'h0, 16'd1);
    `CHK(st[31:12], ex(BCD_STAT_CHECK, BCD_KEY_NOT_READY, BCD_ASC_NOT_READY));
    run(BCD_OP_START_STOP, 8'h00, 32'h0100, 16'd0);
    host.load(BCD_OP_START_STOP, 8'h01, 32'h0, 16'd0);
    host.apb(1'b0, BCD_OFF_STATUS, 32'h0, st, err);
    `CHK(st[1:0], 2'b11);
    host.finish(st);
    host.load(BCD_OP_START_STOP, 8'h01, 32'h5000, 16'd0);
    host.apb(1'b0, BCD_OFF_STATUS, 32'h0, st, err);
    `CHK(st[1:0], 2'b01);
    host.finish(st);
    `CHK(st[11:8], BCD_PWR_SLEEP);
    $display("test stop and sleep done");
    results();
  end
endmodule
